// File: core/lts_defines.svh
// constants for the discovery advertisement scheduler
`ifndef LTS_DEFINES_SVH
`define LTS_DEFINES_SVH

// clock and second tick timing
`define LTS_CLK_PERIOD_NS 4
`define LTS_SEC_PERIOD_NS 1000000000
`define LTS_SEC_CYCLES (`LTS_SEC_PERIOD_NS / `LTS_CLK_PERIOD_NS)

// register byte offsets
`define LTS_REG_GLOBAL 8'h00
`define LTS_REG_PERIOD 8'h04
`define LTS_REG_HOLD 8'h08
`define LTS_REG_GAP 8'h0C
`define LTS_REG_REINIT 8'h10
`define LTS_REG_MODES 8'h14
`define LTS_REG_CMD 8'h18
`define LTS_REG_STATUS 8'h1C

// field positions
`define LTS_GLB_ON_BIT 0
`define LTS_GLB_TLV_LSB 8
`define LTS_CMD_CHANGE_BIT 0
`define LTS_CMD_RESTART_BIT 1
`define LTS_STS_SHUT_LSB 16

// accepted ranges, in seconds or times
`define LTS_PERIOD_MIN 16'h0005
`define LTS_PERIOD_MAX 16'h8000
`define LTS_HOLD_MIN 16'h0002
`define LTS_HOLD_MAX 16'h000A
`define LTS_GAP_MIN 16'h0001
`define LTS_GAP_MAX 16'h2000
`define LTS_REINIT_MIN 16'h0001
`define LTS_REINIT_MAX 16'h000A

// reset values
`define LTS_RST_PERIOD 16'h000A
`define LTS_RST_HOLD 4'h4
`define LTS_RST_GAP 14'h0002
`define LTS_RST_REINIT 4'h2
`define LTS_RST_TLV 5'h1F
`define LTS_RST_MODES 16'h0000

// axi responses
`define LTS_RESP_OKAY 2'h0
`define LTS_RESP_SLVERR 2'h2

`endif

// File: core/lts_pkg.sv
// types shared by the discovery advertisement scheduler
package lts_pkg;

	// per-port discovery mode
	typedef enum logic [1:0] {
		LTS_MODE_DISABLED = 2'b00,
		LTS_MODE_TXRX = 2'b01,
		LTS_MODE_TXONLY = 2'b10,
		LTS_MODE_RXONLY = 2'b11
	} lts_mode_type;

	// per-port scheduler state
	typedef enum logic [1:0] {
		LTS_PS_OFF = 2'b00,
		LTS_PS_RUN = 2'b01,
		LTS_PS_WAIT = 2'b10
	} lts_port_state_type;

endpackage

// File: core/lts_sec_tick.sv
// one-cycle pulse once per second of clock
`timescale 1ns/1ps
module lts_sec_tick #(
	parameter int unsigned CYCLES = 250000000
) (
	input wire logic aclk,
	input wire logic aresetn,
	output logic tick
);

	// cycle counter, wide enough for one second at full rate
	logic [27:0] cnt;

	// count up and pulse on wrap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 28'h0000000;
			tick <= 1'b0;
		end else if (cnt == 28'(CYCLES - 1)) begin
			cnt <= 28'h0000000;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 28'h0000001;
			tick <= 1'b0;
		end
	end

endmodule

// File: core/lts_pair_fifo.sv
// two-entry skid buffer with valid and ready on both sides
`timescale 1ns/1ps
module lts_pair_fifo #(
	parameter int W = 28
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_valid,
	output logic s_ready,
	input wire logic [W-1:0] s_data,
	output logic m_valid,
	input wire logic m_ready,
	output logic [W-1:0] m_data
);

	logic [W-1:0] skid_data; // second entry
	logic skid_valid; // second entry holds a word

	// full only when both entries hold words
	assign s_ready = !skid_valid;

	// head entry drives the output directly, skid catches a stalled push
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			m_valid <= 1'b0;
			m_data <= '0;
			skid_valid <= 1'b0;
			skid_data <= '0;
		end else if (s_valid && s_ready) begin
			if (!m_valid || m_ready) begin
				m_data <= s_data;
				m_valid <= 1'b1;
			end else begin
				skid_data <= s_data;
				skid_valid <= 1'b1;
			end
		end else if (m_valid && m_ready) begin
			if (skid_valid) begin
				m_data <= skid_data;
				skid_valid <= 1'b0;
			end else begin
				m_valid <= 1'b0;
			end
		end
	end

endmodule

// File: core/lts_scheduler.sv
// eight-port discovery frame scheduler with axi4-lite registers
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "lts_defines.svh"

module lts_scheduler
	import lts_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = `LTS_SEC_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic frame_valid,
	input wire logic frame_ready,
	output logic frame_shutdown,
	output logic [2:0] frame_port,
	output logic [4:0] frame_tlv,
	output logic [18:0] frame_ttl,
	input wire logic rx_valid,
	input wire logic [2:0] rx_port,
	output logic rx_pass,
	output logic rx_drop
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// limit a value into a range
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
			input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// merge written bytes into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
	endfunction

	// mode of one port out of the packed mode word
	function automatic lts_mode_type mode_of(input logic [15:0] modes, input logic [2:0] p);
		mode_of = lts_mode_type'(modes[p*2 +: 2]);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// registers and internal state

	logic glb_on; // discovery switched on
	logic [4:0] tlv_en; // optional element enables
	logic [15:0] period; // transmit period, seconds
	logic [3:0] hold; // hold multiplier
	logic [13:0] gap; // minimum spacing, seconds
	logic [3:0] reinit; // restart wait, seconds
	logic [15:0] modes; // two bits per port
	logic [7:0] aw_addr; // held write address
	logic [31:0] w_data; // held write data
	logic [3:0] w_strb; // held write strobes
	logic cmd_change; // one-cycle change pulse
	logic cmd_restart; // one-cycle restart pulse
	logic tick; // one pulse per second
	lts_port_state_type pstate [8]; // per-port state
	logic [15:0] since [8]; // seconds since last frame
	logic [3:0] wait_cnt [8]; // seconds waited after shutdown
	logic [7:0] change_pend; // extra frame owed
	logic [7:0] shut_pend; // shutdown frame owed
	logic [7:0] tx_en; // port may transmit
	logic [7:0] want; // port asks for a slot
	logic [15:0] gap_eff; // spacing after quarter-period limit
	logic [2:0] gnt_idx; // granted port
	logic gnt; // a frame is pushed this cycle
	logic fifo_ready; // buffer has room
	logic [27:0] push_data; // frame descriptor pushed
	logic [27:0] out_data; // frame descriptor at head
	logic do_write; // both write halves held
	logic [19:0] ttl_full; // full product before trim
	logic [31:0] w_word; // strobed write data over a zero word

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite write path

	// address and data taken in either order, answer after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LTS_RESP_OKAY;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				// status is read-only, unmapped offsets are refused
				s_axi_bresp <= (aw_addr > `LTS_REG_CMD || aw_addr[1:0] != 2'h0) ?
					`LTS_RESP_SLVERR : `LTS_RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// unstrobed bytes of the clamped and global registers write as zero
	assign w_word = merge(32'h00000000, w_data, w_strb);

	// register file update, values constrained as written
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			glb_on <= 1'b0;
			tlv_en <= `LTS_RST_TLV;
			period <= `LTS_RST_PERIOD;
			hold <= `LTS_RST_HOLD;
			gap <= `LTS_RST_GAP;
			reinit <= `LTS_RST_REINIT;
			modes <= `LTS_RST_MODES;
			cmd_change <= 1'b0;
			cmd_restart <= 1'b0;
		end else begin
			cmd_change <= 1'b0;
			cmd_restart <= 1'b0;
			if (do_write) begin
				case (aw_addr)
					`LTS_REG_GLOBAL: begin
						glb_on <= w_word[`LTS_GLB_ON_BIT];
						tlv_en <= w_word[`LTS_GLB_TLV_LSB +: 5];
					end
					`LTS_REG_PERIOD: period <= clamp(w_word[15:0],
						`LTS_PERIOD_MIN, `LTS_PERIOD_MAX);
					`LTS_REG_HOLD: hold <= 4'(clamp(w_word[15:0],
						`LTS_HOLD_MIN, `LTS_HOLD_MAX));
					`LTS_REG_GAP: gap <= 14'(clamp(w_word[15:0],
						`LTS_GAP_MIN, `LTS_GAP_MAX));
					`LTS_REG_REINIT: reinit <= 4'(clamp(w_word[15:0],
						`LTS_REINIT_MIN, `LTS_REINIT_MAX));
					`LTS_REG_MODES: modes <= 16'(merge({16'h0000, modes}, w_data, w_strb));
					`LTS_REG_CMD: begin
						// change command requests an extra frame
						cmd_change <= w_strb[0] && w_data[`LTS_CMD_CHANGE_BIT];
						cmd_restart <= w_strb[0] && w_data[`LTS_CMD_RESTART_BIT];
					end
					default: begin
						// unmapped or read-only, nothing stored
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite read path

	// one read at a time, data registered, answer one cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `LTS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `LTS_RESP_OKAY;
			case (s_axi_araddr)
				`LTS_REG_GLOBAL: s_axi_rdata <= {19'h00000, tlv_en, 7'h00, glb_on};
				`LTS_REG_PERIOD: s_axi_rdata <= {16'h0000, period};
				`LTS_REG_HOLD: s_axi_rdata <= {28'h0000000, hold};
				`LTS_REG_GAP: s_axi_rdata <= {18'h00000, gap};
				`LTS_REG_REINIT: s_axi_rdata <= {28'h0000000, reinit};
				`LTS_REG_MODES: s_axi_rdata <= {16'h0000, modes};
				`LTS_REG_CMD: s_axi_rdata <= 32'h00000000;
				`LTS_REG_STATUS: begin
					for (int i = 0; i < 8; i++) begin
						s_axi_rdata[i*2 +: 2] <= pstate[i];
					end
					s_axi_rdata[`LTS_STS_SHUT_LSB +: 8] <= shut_pend;
					s_axi_rdata[31:24] <= 8'h00;
				end
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `LTS_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// scheduling decisions

	// seconds come from the clock, not from software
	lts_sec_tick #(
		.CYCLES(SEC_CYCLES)
	) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick)
	);

	// per-port requests and lowest-index grant; fairness is not needed
	// since one slot per cycle is far faster than any second timer
	always_comb begin
		// spacing never above a quarter of the period
		gap_eff = ({2'h0, gap} > (period >> 2)) ? (period >> 2) : {2'h0, gap};
		gnt_idx = 3'h0;
		gnt = 1'b0;
		for (int i = 0; i < 8; i++) begin
			// disabled and receive-only ports send no normal frames, only an owed shutdown frame
			tx_en[i] = glb_on && (mode_of(modes, 3'(i)) == LTS_MODE_TXRX ||
				mode_of(modes, 3'(i)) == LTS_MODE_TXONLY);
			// every normal frame waits out the spacing
			want[i] = shut_pend[i] || (pstate[i] == LTS_PS_RUN && tx_en[i] &&
				(since[i] >= period || change_pend[i]) && since[i] >= gap_eff);
		end
		for (int i = 7; i >= 0; i--) begin
			if (want[i]) begin
				gnt_idx = 3'(i);
			end
		end
		gnt = (want != 8'h00) && fifo_ready;
	end

	// validity carried in the frame is period times hold
	assign ttl_full = period * {12'h000, hold};

	// element mask cleared for shutdown frames, else from enables
	assign push_data = shut_pend[gnt_idx] ? {1'b1, gnt_idx, 5'h00, 19'h00000} :
		{1'b0, gnt_idx, tlv_en, ttl_full[18:0]};

	////////////////////////////////////////////////////////////////////////////
	// per-port state machines

	// off, running, or waiting after a shutdown frame
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			change_pend <= 8'h00;
			shut_pend <= 8'h00;
			for (int i = 0; i < 8; i++) begin
				pstate[i] <= LTS_PS_OFF;
				since[i] <= 16'h0000;
				wait_cnt[i] <= 4'h0;
			end
		end else begin
			for (int i = 0; i < 8; i++) begin
				case (pstate[i])
					LTS_PS_OFF: begin
						if (tx_en[i]) begin
							// first frame goes out at once
							pstate[i] <= LTS_PS_RUN;
							since[i] <= 16'hFFFF;
							change_pend[i] <= 1'b1;
						end
					end
					LTS_PS_RUN: begin
						if (!tx_en[i] || cmd_restart) begin
							// shutdown owed on disable, off or restart
							pstate[i] <= LTS_PS_WAIT;
							shut_pend[i] <= 1'b1;
							change_pend[i] <= 1'b0;
							wait_cnt[i] <= 4'h0;
						end else if (gnt && gnt_idx == 3'(i)) begin
							since[i] <= 16'h0000;
							// a change in the send cycle still wins
							change_pend[i] <= cmd_change;
						end else begin
							change_pend[i] <= change_pend[i] || cmd_change;
							if (tick && since[i] != 16'hFFFF) begin
								since[i] <= since[i] + 16'h0001;
							end
						end
					end
					LTS_PS_WAIT: begin
						if (shut_pend[i]) begin
							if (gnt && gnt_idx == 3'(i)) begin
								shut_pend[i] <= 1'b0;
							end
						end else if (wait_cnt[i] >= reinit) begin
							// new initialisation only after the wait
							pstate[i] <= tx_en[i] ? LTS_PS_RUN : LTS_PS_OFF;
							since[i] <= 16'hFFFF;
							change_pend[i] <= tx_en[i];
						end else if (tick) begin
							wait_cnt[i] <= wait_cnt[i] + 4'h1;
						end
					end
					default: begin
						pstate[i] <= LTS_PS_OFF;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frame descriptor buffer

	// a stalled receiver fills the buffer, then grants stop
	lts_pair_fifo #(
		.W(28)
	) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_valid(gnt),
		.s_ready(fifo_ready),
		.s_data(push_data),
		.m_valid(frame_valid),
		.m_ready(frame_ready),
		.m_data(out_data)
	);

	assign frame_shutdown = out_data[27];
	assign frame_port = out_data[26:24];
	assign frame_tlv = out_data[23:19];
	assign frame_ttl = out_data[18:0];

	////////////////////////////////////////////////////////////////////////////
	// received frame filter

	// one verdict per received frame, one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_pass <= 1'b0;
			rx_drop <= 1'b0;
		end else begin
			// both and receive-only modes pass received frames on
			rx_pass <= rx_valid && glb_on && (mode_of(modes, rx_port) == LTS_MODE_TXRX ||
				mode_of(modes, rx_port) == LTS_MODE_RXONLY);
			rx_drop <= rx_valid && !(glb_on && (mode_of(modes, rx_port) == LTS_MODE_TXRX ||
				mode_of(modes, rx_port) == LTS_MODE_RXONLY));
		end
	end

endmodule

// File: verif/lts_scheduler_assertions.sv
// port checker for the discovery frame scheduler
`timescale 1ns/1ps
module lts_scheduler_chk #(
	parameter int unsigned SEC_CYCLES = 20
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic frame_valid,
	input wire logic frame_ready,
	input wire logic frame_shutdown,
	input wire logic [2:0] frame_port,
	input wire logic [4:0] frame_tlv,
	input wire logic [18:0] frame_ttl,
	input wire logic rx_valid,
	input wire logic rx_pass,
	input wire logic rx_drop
);
	// one clock domain, so clock and reset are given once
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	// quiet out of reset
	chk_reset_quiet:
	assert property (disable iff (1'b0) !aresetn |=> !frame_valid && !rx_pass && !rx_drop)
		else $error("outputs active after reset");
	chk_shut_empty:
	assert property (frame_valid && frame_shutdown |-> frame_tlv == 5'h00 && frame_ttl == 19'h00000)
		else $error("shutdown frame carries elements or validity");
	chk_ttl_range:
	assert property (frame_valid && !frame_shutdown |-> frame_ttl >= 19'h0000A && frame_ttl <= 19'h50000)
		else $error("validity outside period times hold range");
	chk_frame_hold:
	assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame_port)
		&& $stable(frame_tlv) && $stable(frame_ttl) && $stable(frame_shutdown))
		else $error("frame changed while stalled");
	chk_rx_verdict:
	assert property (rx_valid |=> rx_pass != rx_drop)
		else $error("received frame without single verdict");
	chk_rx_idle:
	assert property (!rx_valid |=> !rx_pass && !rx_drop)
		else $error("verdict without received frame");
	// read answer one cycle after address
	chk_read_answer:
	assert property (s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	// read data held until taken
	chk_rdata_hold:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	// write response held until taken
	chk_bresp_hold:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before taken");
endmodule

bind lts_scheduler lts_scheduler_chk #(.SEC_CYCLES(SEC_CYCLES)) i_lts_scheduler_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .frame_valid(frame_valid),
	.frame_ready(frame_ready), .frame_shutdown(frame_shutdown), .frame_port(frame_port),
	.frame_tlv(frame_tlv), .frame_ttl(frame_ttl), .rx_valid(rx_valid), .rx_pass(rx_pass),
	.rx_drop(rx_drop)
);

// File: verif/lts_nbr_model.sv
// neighbour model: takes discovery frames, sends received ones
`timescale 1ns/1ps
module lts_nbr_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic stall,
	input wire logic frame_valid,
	output logic frame_ready,
	input wire logic frame_shutdown,
	input wire logic [2:0] frame_port,
	input wire logic [4:0] frame_tlv,
	input wire logic [18:0] frame_ttl,
	output logic rx_valid,
	output logic [2:0] rx_port
);
	int unsigned cyc = 0; // cycle stamp for accepted frames
	logic [27:0] fq[$]; // shutdown, port, elements, validity
	int unsigned tq[$]; // stamp of each accepted frame
	initial begin
		frame_ready = 1'b0;
		rx_valid = 1'b0;
		rx_port = 3'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// ready lags stall by one edge, like a busy receiver
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		frame_ready <= aresetn && !stall;
		if (frame_valid && frame_ready) begin
			fq.push_back({frame_shutdown, frame_port, frame_tlv, frame_ttl});
			tq.push_back(cyc);
		end
	end
	// one received frame; port line inverted after so stale values never match
	task automatic send_rx(input logic [2:0] p);
		rx_valid <= 1'b1;
		rx_port <= p;
		@(posedge aclk);
		rx_valid <= 1'b0;
		rx_port <= ~p;
	endtask
endmodule

// File: verif/test_lts_scheduler.sv
// self-checking bench for the discovery frame scheduler
`timescale 1ns/1ps
`include "lts_defines.svh"
module test_lts_scheduler;
	localparam int SEC = 20; // shortened second keeps the run brief
	localparam logic [7:0] CA [8] = '{`LTS_REG_PERIOD, `LTS_REG_PERIOD, `LTS_REG_HOLD,
		`LTS_REG_HOLD, `LTS_REG_GAP, `LTS_REG_GAP, `LTS_REG_REINIT, `LTS_REG_REINIT};
	localparam logic [31:0] CW [8] = '{3, 32'h9000, 1, 15, 0, 32'h3000, 0, 11};
	localparam logic [31:0] CE [8] = '{5, 32'h8000, 2, 10, 1, 32'h2000, 1, 10};
	localparam logic [27:0] F2 = {1'b0, 3'h2, 5'h15, 19'h0003C}; // port 2 normal frame
	logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic frame_valid, frame_ready, frame_shutdown, rx_valid, rx_pass, rx_drop;
	logic [2:0] frame_port, rx_port;
	logic [4:0] frame_tlv;
	logic [18:0] frame_ttl;
	int miscompares = 0, tests_run = 0, fi = 0;
	int unsigned last_t = 0;
	always #2 aclk = ~aclk;
	lts_scheduler #(.SEC_CYCLES(SEC)) i_lts_scheduler (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_valid, .frame_ready,
		.frame_shutdown, .frame_port, .frame_tlv, .frame_ttl, .rx_valid, .rx_port, .rx_pass,
		.rx_drop);
	lts_nbr_model i_lts_nbr_model (.aclk, .aresetn, .stall, .frame_valid, .frame_ready,
		.frame_shutdown, .frame_port, .frame_tlv, .frame_ttl, .rx_valid, .rx_port);
	////////////////////////////////////////////////////////////////////////////////
	// value compare
	task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// timing compare, cycles between frames
	task automatic chk_gap(input int unsigned lo, input int unsigned hi, input int unsigned g);
		tests_run++;
		if (g < lo || g > hi) begin
			miscompares++;
			$display("BAD frame gap expected %0d to %0d seen %0d", lo, hi, g);
		end
	endtask
	// write: bready held high from the start until the response shows
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk_val("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		// idle edge so a following call never re-raises bready in this step
		@(posedge aclk);
	endtask
	// read: rready held high from the start, data taken at the answer edge
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
		chk_val("rdata", e, d & ((a == `LTS_REG_STATUS) ? 32'h00FFFFFF : 32'hFFFFFFFF));
		chk_val("rresp", {30'h0, er}, {30'h0, r});
		@(posedge aclk);
	endtask
	// next frame taken by the neighbour, with its spacing
	task automatic exp_frame(input logic [27:0] e, input int unsigned lo, input int unsigned hi);
		while (i_lts_nbr_model.fq.size() <= fi) @(posedge aclk);
		chk_val("frame", {4'h0, e}, {4'h0, i_lts_nbr_model.fq[fi]});
		chk_gap(lo, hi, i_lts_nbr_model.tq[fi] - last_t);
		last_t = i_lts_nbr_model.tq[fi];
		fi++;
	endtask
	// one received frame; the verdict stands one cycle, read just after its edge
	task automatic rx_chk(input logic [2:0] p, input logic ep);
		i_lts_nbr_model.send_rx(p);
		#1;
		chk_val("rx_pass", {31'h0, ep}, {31'h0, rx_pass});
		chk_val("rx_drop", {31'h0, ~ep}, {31'h0, rx_drop});
		@(posedge aclk);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// watchdog: whole sequence needs well under 3000 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		tally_and_finish;
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(`LTS_REG_GLOBAL, 32'h00001F00, `LTS_RESP_OKAY);
		rd_chk(`LTS_REG_PERIOD, 32'h0000000A, `LTS_RESP_OKAY);
		rd_chk(`LTS_REG_HOLD, 32'h00000004, `LTS_RESP_OKAY);
		rd_chk(`LTS_REG_GAP, 32'h00000002, `LTS_RESP_OKAY);
		rd_chk(`LTS_REG_REINIT, 32'h00000002, `LTS_RESP_OKAY);
		rd_chk(`LTS_REG_MODES, 32'h00000000, `LTS_RESP_OKAY);
		rd_chk(`LTS_REG_STATUS, 32'h00000000, `LTS_RESP_OKAY);
		rd_chk(8'h20, 32'h00000000, `LTS_RESP_SLVERR);
		axi_wr(`LTS_REG_STATUS, 32'h00000001, `LTS_RESP_SLVERR);
		// out-of-range settings are pulled to the nearest limit
		for (int k = 0; k < 8; k++) begin
			axi_wr(CA[k], CW[k], `LTS_RESP_OKAY);
			rd_chk(CA[k], CE[k], `LTS_RESP_OKAY);
		end
		// only the strobed byte lands, the others write as zero
		s_axi_wstrb <= 4'h2;
		axi_wr(`LTS_REG_PERIOD, 32'h00001234, `LTS_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd_chk(`LTS_REG_PERIOD, 32'h00001200, `LTS_RESP_OKAY);
		axi_wr(`LTS_REG_PERIOD, 32'h00000014, `LTS_RESP_OKAY);
		axi_wr(`LTS_REG_HOLD, 32'h00000003, `LTS_RESP_OKAY);
		axi_wr(`LTS_REG_GAP, 32'h00000004, `LTS_RESP_OKAY);
		axi_wr(`LTS_REG_REINIT, 32'h00000003, `LTS_RESP_OKAY);
		axi_wr(`LTS_REG_GLOBAL, 32'h00001501, `LTS_RESP_OKAY);
		// port 2 both ways: first frame at once, then change, capped gap, period
		axi_wr(`LTS_REG_MODES, 32'h00000010, `LTS_RESP_OKAY);
		last_t = i_lts_nbr_model.cyc;
		exp_frame(F2, 0, 8);
		axi_wr(`LTS_REG_CMD, 32'h00000001, `LTS_RESP_OKAY);
		exp_frame(F2, 3 * SEC, 4 * SEC + 8);
		axi_wr(`LTS_REG_GAP, 32'h00000008, `LTS_RESP_OKAY);
		axi_wr(`LTS_REG_CMD, 32'h00000001, `LTS_RESP_OKAY);
		exp_frame(F2, 4 * SEC, 5 * SEC + 8);
		rd_chk(`LTS_REG_GAP, 32'h00000008, `LTS_RESP_OKAY);
		exp_frame(F2, 19 * SEC, 20 * SEC + 8);
		// stalled neighbour: two new ports queue up, lowest first, none lost
		stall <= 1'b1;
		axi_wr(`LTS_REG_MODES, 32'h00000016, `LTS_RESP_OKAY);
		repeat (20) @(posedge aclk);
		stall <= 1'b0;
		exp_frame({1'b0, 3'h0, 5'h15, 19'h0003C}, 20, 60);
		exp_frame({1'b0, 3'h1, 5'h15, 19'h0003C}, 0, 4);
		rx_chk(3'h0, 1'b0);
		rx_chk(3'h1, 1'b1);
		// disabling two ports sends their shutdown frames
		axi_wr(`LTS_REG_MODES, 32'h00000010, `LTS_RESP_OKAY);
		exp_frame({1'b1, 3'h0, 5'h00, 19'h00000}, 0, 200);
		exp_frame({1'b1, 3'h1, 5'h00, 19'h00000}, 0, 4);
		rx_chk(3'h1, 1'b0);
		repeat (5 * SEC) @(posedge aclk);
		rd_chk(`LTS_REG_STATUS, 32'h00000010, `LTS_RESP_OKAY);
		// restart: shutdown, wait, then a fresh first frame
		axi_wr(`LTS_REG_CMD, 32'h00000002, `LTS_RESP_OKAY);
		exp_frame({1'b1, 3'h2, 5'h00, 19'h00000}, 0, 10 * SEC);
		exp_frame(F2, 2 * SEC, 4 * SEC + 8);
		// receive-only port analyses and never sends
		axi_wr(`LTS_REG_MODES, 32'h000000D0, `LTS_RESP_OKAY);
		rx_chk(3'h3, 1'b1);
		rx_chk(3'h2, 1'b1);
		// discovery off: shutdown from the sender, everything dropped
		axi_wr(`LTS_REG_GLOBAL, 32'h00001500, `LTS_RESP_OKAY);
		exp_frame({1'b1, 3'h2, 5'h00, 19'h00000}, 0, 10 * SEC);
		rx_chk(3'h3, 1'b0);
		tally_and_finish;
	end
endmodule
